// File: liu_drive_cfg.svh
// Offsets, field positions and reset values of the line interface drive register
`ifndef LIU_DRIVE_CFG_SVH
`define LIU_DRIVE_CFG_SVH

`define LIDC_OFFSET 8'h80
`define LIDC_RESET 8'h08
`define LIDC_CHANNELS 8
`define LIDC_BIT_SPARE_HI 7
`define LIDC_BIT_SPARE_LO 6
`define LIDC_BIT_RX_EQ_BYPASS 5
`define LIDC_BIT_TX_ALL_ONES 4
`define LIDC_BIT_CODEC_DISABLE 3
`define LIDC_BIT_BUILD_OUT 2
`define LIDC_BIT_REMOTE_LOOP 1
`define LIDC_BIT_LOCAL_LOOP 0
`define LIDC_UNMAPPED_DATA 8'h00

`endif

// File: liu_drive_pkg.sv
// Types shared by the line interface drive control block
`default_nettype none

package liu_drive_pkg;

  typedef logic [7:0] ctlByte_t;
  typedef logic [2:0] chanIdx_t;

  // LIU control pins of one channel, in register bit order 5 down to 0
  typedef struct packed {
    logic rxEqBypass;
    logic txAllOnes;
    logic codecDisable;
    logic buildOutSelect;
    logic remoteLoop;
    logic localLoop;
  } liuPins_t;

  // One microprocessor access
  typedef struct packed {
    logic sel;
    logic wr;
    logic rd;
    chanIdx_t chan;
    logic [7:0] addr;
    ctlByte_t wdata;
  } cpuReq_t;

endpackage

`default_nettype wire

// File: liu_drive_channel.sv
// One channel's line interface drive register and its pin mapping
`timescale 1ns/1ps
`default_nettype none
`include "liu_drive_cfg.svh"

module liu_drive_channel
  import liu_drive_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Write port
  input wire logic wrEn,
  input wire ctlByte_t wrData,
  // Register and pins
  output ctlByte_t ctl,
  output liuPins_t pins
);

  // ****************************************
  // Storage
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl <= `LIDC_RESET;
    end else if (wrEn) begin
      ctl <= wrData;
    end
  end

  // ****************************************
  // Pins mirror the stored bits, no gating
  // ****************************************
  assign pins.rxEqBypass = ctl[`LIDC_BIT_RX_EQ_BYPASS];
  assign pins.txAllOnes = ctl[`LIDC_BIT_TX_ALL_ONES];
  assign pins.codecDisable = ctl[`LIDC_BIT_CODEC_DISABLE];
  assign pins.buildOutSelect = ctl[`LIDC_BIT_BUILD_OUT];
  assign pins.remoteLoop = ctl[`LIDC_BIT_REMOTE_LOOP];
  assign pins.localLoop = ctl[`LIDC_BIT_LOCAL_LOOP];

endmodule

`default_nettype wire

// File: line_interface_drive_control.sv
// Eight-channel line interface drive control register bank with LIU pins
// Function
// - Each channel has 8-bit read/write register at 0x80, reset 0x08.
// - Bit 5 drives receive equalizer bypass pin high or low.
// - Bit 4 drives transmit all-ones pin high or low.
// - Bit 3 drives LIU encoder disable pin high or low.
// - Bit 2 drives transmit build-out select pin high or low.
// - Bit 1 drives remote loop-back pin high or low.
// - Bit 0 drives local loop-back pin high or low.
// - Pins mirror register bits only, usable as general outputs.
`timescale 1ns/1ps
`default_nettype none
`include "liu_drive_cfg.svh"

module line_interface_drive_control
  import liu_drive_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Microprocessor port, synchronous to clk
  input wire cpuReq_t cpuReq,
  output logic cpuAck,
  output ctlByte_t cpuRdata,
  // LIU control pins, one bit per channel
  output logic [7:0] rxEqBypassOut,
  output logic [7:0] txAllOnesOut,
  output logic [7:0] codecDisableOut,
  output logic [7:0] buildOutSelectOut,
  output logic [7:0] remoteLoopbackOut,
  output logic [7:0] localLoopbackOut
);

  // ****************************************
  // Address decode
  // ****************************************
  function automatic logic hitsDrive(input logic [7:0] addr);
    hitsDrive = (addr == `LIDC_OFFSET);
  endfunction

  wire logic wrHit;
  wire logic rdStrobe;
  wire logic rdHit;
  assign wrHit = cpuReq.sel && cpuReq.wr && hitsDrive(cpuReq.addr);
  assign rdStrobe = cpuReq.sel && cpuReq.rd;
  assign rdHit = rdStrobe && hitsDrive(cpuReq.addr);

  // ****************************************
  // Channel registers
  // ****************************************
  ctlByte_t ctlReg [`LIDC_CHANNELS];
  liuPins_t chanPins [`LIDC_CHANNELS];

  genvar gi;
  generate
    for (gi = 0; gi < `LIDC_CHANNELS; gi++) begin : gChan
      wire logic chanWr;
      assign chanWr = wrHit && (cpuReq.chan == chanIdx_t'(gi));
      liu_drive_channel uChan (
        .clk(clk),
        .rst_b(rst_b),
        .wrEn(chanWr),
        .wrData(cpuReq.wdata),
        .ctl(ctlReg[gi]),
        .pins(chanPins[gi])
      );
      // Pins leave straight from the channel flops so they move in the cycle after the write
      assign rxEqBypassOut[gi] = chanPins[gi].rxEqBypass;
      assign txAllOnesOut[gi] = chanPins[gi].txAllOnes;
      assign codecDisableOut[gi] = chanPins[gi].codecDisable;
      assign buildOutSelectOut[gi] = chanPins[gi].buildOutSelect;
      assign remoteLoopbackOut[gi] = chanPins[gi].remoteLoop;
      assign localLoopbackOut[gi] = chanPins[gi].localLoop;
    end
  endgenerate

  // ****************************************
  // Read data and acknowledge
  // ****************************************
  // Unmapped offsets answer with zero so software never hangs on a stray address
  wire ctlByte_t next_cpuRdata;
  wire logic next_cpuAck;
  assign next_cpuRdata = rdHit ? ctlReg[cpuReq.chan] : `LIDC_UNMAPPED_DATA;
  assign next_cpuAck = cpuReq.sel && (cpuReq.rd || cpuReq.wr);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cpuRdata <= `LIDC_UNMAPPED_DATA;
      cpuAck <= 1'b0;
    end else begin
      cpuRdata <= next_cpuRdata;
      cpuAck <= next_cpuAck;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic afterReset;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      afterReset <= 1'b0;
    end else begin
      afterReset <= 1'b1;
    end
  end

  property p_resetValue;
    @(posedge clk) disable iff (!rst_b)
      !afterReset |-> (ctlReg[0] == `LIDC_RESET) && (codecDisableOut == 8'hff) && (localLoopbackOut == 8'h00);
  endproperty
  a_resetValue: assert property (p_resetValue) else $error("Drive register not at reset value");

  sequence s_write;
    wrHit;
  endsequence

  sequence s_stored;
    ctlReg[$past(cpuReq.chan)] == $past(cpuReq.wdata);
  endsequence

  property p_writeStores;
    @(posedge clk) disable iff (!rst_b)
      s_write |=> s_stored;
  endproperty
  a_writeStores: assert property (p_writeStores) else $error("Write not stored");

  property p_readBack;
    @(posedge clk) disable iff (!rst_b)
      rdHit && !wrHit |=> cpuAck && (cpuRdata == ctlReg[$past(cpuReq.chan)]);
  endproperty
  a_readBack: assert property (p_readBack) else $error("Read data does not match register");

  // Every selected access is answered exactly once, the cycle after it is taken
  property p_ackFollows;
    @(posedge clk) disable iff (!rst_b)
      1'b1 |=> cpuAck == $past(cpuReq.sel && (cpuReq.rd || cpuReq.wr));
  endproperty
  a_ackFollows: assert property (p_ackFollows) else $error("Acknowledge not one cycle after access");

  property p_spareBits;
    @(posedge clk) disable iff (!rst_b)
      s_write |=> (ctlReg[$past(cpuReq.chan)][7:6] == $past(cpuReq.wdata[7:6]));
  endproperty
  a_spareBits: assert property (p_spareBits) else $error("Spare bits not kept");

  property p_pinsHoldNoWrite;
    @(posedge clk) disable iff (!rst_b)
      !wrHit |=> $stable(rxEqBypassOut) && $stable(txAllOnesOut) && $stable(localLoopbackOut)
        && $stable(codecDisableOut) && $stable(buildOutSelectOut) && $stable(remoteLoopbackOut);
  endproperty
  a_pinsHoldNoWrite: assert property (p_pinsHoldNoWrite) else $error("Pin moved without a write");

  generate
    for (gi = 0; gi < `LIDC_CHANNELS; gi++) begin : gCheck
      property p_eqBypass;
        @(posedge clk) disable iff (!rst_b)
          wrHit && (cpuReq.chan == chanIdx_t'(gi)) |=> rxEqBypassOut[gi] == $past(cpuReq.wdata[5]);
      endproperty
      a_eqBypass: assert property (p_eqBypass) else $error("Equalizer bypass pin wrong");

      property p_allOnes;
        @(posedge clk) disable iff (!rst_b)
          wrHit && (cpuReq.chan == chanIdx_t'(gi)) |=> txAllOnesOut[gi] == $past(cpuReq.wdata[4]);
      endproperty
      a_allOnes: assert property (p_allOnes) else $error("All-ones pin wrong");

      property p_codecDis;
        @(posedge clk) disable iff (!rst_b)
          wrHit && (cpuReq.chan == chanIdx_t'(gi)) |=> codecDisableOut[gi] == $past(cpuReq.wdata[3]);
      endproperty
      a_codecDis: assert property (p_codecDis) else $error("Encoder disable pin wrong");

      property p_buildOut;
        @(posedge clk) disable iff (!rst_b)
          wrHit && (cpuReq.chan == chanIdx_t'(gi)) |=> buildOutSelectOut[gi] == $past(cpuReq.wdata[2]);
      endproperty
      a_buildOut: assert property (p_buildOut) else $error("Build-out pin wrong");

      property p_remoteLoop;
        @(posedge clk) disable iff (!rst_b)
          wrHit && (cpuReq.chan == chanIdx_t'(gi)) |=> remoteLoopbackOut[gi] == $past(cpuReq.wdata[1]);
      endproperty
      a_remoteLoop: assert property (p_remoteLoop) else $error("Remote loop pin wrong");

      property p_localLoop;
        @(posedge clk) disable iff (!rst_b)
          wrHit && (cpuReq.chan == chanIdx_t'(gi)) |=> localLoopbackOut[gi] == $past(cpuReq.wdata[0]);
      endproperty
      a_localLoop: assert property (p_localLoop) else $error("Local loop pin wrong");

      property p_otherChanStill;
        @(posedge clk) disable iff (!rst_b)
          wrHit && (cpuReq.chan != chanIdx_t'(gi)) |=> $stable(ctlReg[gi]);
      endproperty
      a_otherChanStill: assert property (p_otherChanStill) else $error("Other channel disturbed");
    end
  endgenerate

endmodule

`default_nettype wire

// File: liu_model.sv
// Behavioural model of the line interface unit behind the drive control pins
`timescale 1ns/1ps
`default_nettype none

module liu_model (
  // Control pins from the framer, one bit per channel
  input wire logic [7:0] eqBypassIn,
  input wire logic [7:0] allOnesIn,
  input wire logic [7:0] codecDisIn,
  input wire logic [7:0] buildOutIn,
  input wire logic [7:0] remoteLoopIn,
  input wire logic [7:0] localLoopIn,
  // Line behaviour per channel
  output logic [7:0] equalizerOn,
  output logic [7:0] sendsAllOnes,
  output logic [7:0] encoderOn,
  output logic [7:0] squarePulses,
  output logic [15:0] loopMode
);
  // ****************
  // Line behaviour
  // ****************
  assign equalizerOn = ~eqBypassIn;
  assign sendsAllOnes = allOnesIn;
  assign encoderOn = ~codecDisIn;
  // Modelled as a DS3 unit; an E3 unit has no build-out and ignores the pin
  assign squarePulses = buildOutIn;
  // Two bits per channel: 0 normal, 1 analog local, 2 remote, 3 digital local
  for (genvar i = 0; i < 8; i++) begin : g_loop
    assign loopMode[2*i+:2] = {remoteLoopIn[i], localLoopIn[i]};
  end
endmodule

`default_nettype wire

// File: testbench.sv
// Self-checking bench for the line interface drive control bank
`timescale 1ns/1ps
`default_nettype none
`include "liu_drive_cfg.svh"

module testbench
  import liu_drive_pkg::*;
;
  logic clk;
  logic rst_b;
  cpuReq_t cpuReq;
  logic cpuAck;
  ctlByte_t cpuRdata;
  logic [7:0] rxEq, txOnes, codecDis, buildOut, remLoop, locLoop;
  logic [15:0] loopMode;
  logic [7:0] eqOn, allOnesL, encOn, square;
  logic [7:0] rndAddr;
  ctlByte_t expReg [8];
  logic [7:0] lfsr;
  int error_cnt = 0;
  int n_compared = 0;

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  line_interface_drive_control line_interface_drive_control_inst (.clk(clk), .rst_b(rst_b),
    .cpuReq(cpuReq), .cpuAck(cpuAck), .cpuRdata(cpuRdata), .rxEqBypassOut(rxEq), .txAllOnesOut(txOnes),
    .codecDisableOut(codecDis), .buildOutSelectOut(buildOut), .remoteLoopbackOut(remLoop),
    .localLoopbackOut(locLoop));
  liu_model liu_model_inst (.eqBypassIn(rxEq), .allOnesIn(txOnes), .codecDisIn(codecDis),
    .buildOutIn(buildOut), .remoteLoopIn(remLoop), .localLoopIn(locLoop), .equalizerOn(eqOn),
    .sendsAllOnes(allOnesL), .encoderOn(encOn), .squarePulses(square), .loopMode(loopMode));

  // ****************
  // Helpers
  // ****************
  function automatic logic [7:0] nextRand(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic check(input string what, input logic [7:0] expV, input logic [7:0] seenV);
    n_compared++;
    if (seenV !== expV) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, expV, seenV);
    end
  endtask

  task automatic end_sim();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic checkPins();
    string what;
    logic [7:0] expP;
    logic [7:0] seenP;
    for (int c = 0; c < 8; c++) begin
      what = $sformatf("pins ch%0d", c);
      expP = {2'b00, expReg[c][5:0]};
      seenP = {2'b00, rxEq[c], txOnes[c], codecDis[c], buildOut[c], remLoop[c], locLoop[c]};
      check(what, expP, seenP);
      // Line behaviour of a DS3 unit: equalizer and encoder run while their pins are low
      what = $sformatf("line ch%0d", c);
      expP = {4'h0, ~expReg[c][5], expReg[c][4], ~expReg[c][3], expReg[c][2]};
      seenP = {4'h0, eqOn[c], allOnesL[c], encOn[c], square[c]};
      check(what, expP, seenP);
    end
    check("loop mode ch3", {6'd0, expReg[3][1:0]}, {6'd0, loopMode[7:6]});
  endtask

  // One access, then its answer and every channel's pins are compared
  task automatic access(input logic w, input logic r, input chanIdx_t ch, input logic [7:0] addr,
                        input ctlByte_t wd);
    ctlByte_t expRd;
    int i;
    @(posedge clk);
    cpuReq <= '{sel: 1'b1, wr: w, rd: r, chan: ch, addr: addr, wdata: wd};
    @(posedge clk);
    cpuReq <= '0;
    expRd = (r && addr == `LIDC_OFFSET) ? expReg[ch] : `LIDC_UNMAPPED_DATA;
    if (w && addr == `LIDC_OFFSET) begin
      expReg[ch] = wd;
    end
    @(negedge clk);
    for (i = 0; i < 3 && cpuAck !== 1'b1; i++) @(negedge clk);
    if (cpuAck !== 1'b1) begin
      error_cnt++;
      end_sim();
    end
    check("read data", expRd, cpuRdata);
    checkPins();
  endtask

  task automatic resetAll();
    rst_b <= 1'b0;
    for (int c = 0; c < 8; c++) expReg[c] = `LIDC_RESET;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    for (int c = 0; c < 8; c++) access(1'b0, 1'b1, chanIdx_t'(c), `LIDC_OFFSET, 8'h00);
  endtask

  // ****************
  // Main sequence
  // ****************
  initial begin
    rst_b = 1'b0;
    cpuReq = '0;
    lfsr = 8'h04;
    resetAll();
    // Each bit alone on the top channel, read back
    for (int b = 0; b < 8; b++) begin
      access(1'b1, 1'b0, 3'd7, `LIDC_OFFSET, ctlByte_t'(8'h01 << b));
      access(1'b0, 1'b1, 3'd7, `LIDC_OFFSET, 8'h00);
    end
    for (int m = 0; m < 4; m++) access(1'b1, 1'b0, 3'd3, `LIDC_OFFSET, ctlByte_t'(m));
    // Framer line-codes itself and the cable is short
    access(1'b1, 1'b0, 3'd0, `LIDC_OFFSET, 8'h0C);
    // Write with read in one access, then an unmapped offset
    access(1'b1, 1'b1, 3'd5, `LIDC_OFFSET, 8'hFF);
    access(1'b1, 1'b1, 3'd5, 8'h81, 8'h00);
    access(1'b0, 1'b1, 3'd5, `LIDC_OFFSET, 8'h00);
    repeat (60) begin
      lfsr = nextRand(lfsr);
      rndAddr = (lfsr[4:3] == 2'b00) ? lfsr : `LIDC_OFFSET;
      access(lfsr[7], lfsr[6] | ~lfsr[7], lfsr[2:0], rndAddr, nextRand(lfsr));
    end
    @(posedge clk);
    resetAll();
    end_sim();
  end
endmodule

`default_nettype wire
